// file: rtl/scl_pkg.sv
package scl_pkg;

  // ----------------------------------------------------------------------
  // Character codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CH_SEMI  = 8'h3B;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_EQ    = 8'h3D;
  localparam logic [7:0] CH_DOT   = 8'h2E;
  localparam logic [7:0] CH_OR    = 8'h7C;
  localparam logic [7:0] CH_AND   = 8'h26;
  localparam logic [7:0] CH_HASH  = 8'h23;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_ONE   = 8'h31;
  localparam logic [7:0] CH_XLOW  = 8'h78;
  localparam logic [7:0] CH_XUP   = 8'h58;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_CR    = 8'h0D;

  // ----------------------------------------------------------------------
  // Field sizes and counts
  // ----------------------------------------------------------------------
  localparam int          IDX_DIGITS = 4;
  localparam int          SUB_DIGITS = 2;
  localparam int          BIT_DIGITS = 2;
  localparam int          SW_MIN     = 1;
  localparam int          SW_MAX     = 4;
  localparam logic [7:0]  SUB_DEFAULT = 8'h00;
  localparam logic [31:0] VAL_RESET   = 32'h00000000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_WRITE,
    OP_OR,
    OP_AND,
    OP_BIT
  } scl_op_t;

  typedef struct packed {
    logic [15:0] index;
    logic [7:0]  subIndex;
    logic [31:0] value;
  } scl_wr_t;

  typedef struct packed {
    logic [15:0] index;
    logic [7:0]  subIndex;
  } scl_rd_t;

endpackage

// file: rtl/scl_char_class.sv
`timescale 1ns/10ps

// Classifies one ASCII character as a hex digit and a decimal digit
module scl_char_class (
  input  wire logic [7:0] ch,
  output logic            isHex,
  output logic            isDec,
  output logic [3:0]      nibble
);

  always_comb begin
    isHex  = 1'b1;
    isDec  = 1'b0;
    nibble = 4'h0;
    if (ch >= 8'h30 && ch <= 8'h39) begin
      isDec  = 1'b1;
      nibble = 4'(ch - 8'h30);
    end else if (ch >= 8'h41 && ch <= 8'h46) begin
      nibble = 4'(ch - 8'h37);
    end else if (ch >= 8'h61 && ch <= 8'h66) begin
      nibble = 4'(ch - 8'h57);
    end else begin
      isHex = 1'b0;
    end
  end

endmodule

// file: rtl/scl_interp.sv
`timescale 1ns/10ps

module scl_interp (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                cfgPresent,
  input  wire logic [7:0]          chData,
  input  wire logic                chValid,
  input  wire logic                chLast,
  input  wire logic [3:0]          dipSwitch,
  input  wire logic [31:0]         rdValue,
  output logic                     chReady,
  output logic                     cfgCreate,
  output logic                     sweepStart,
  output scl_pkg::scl_rd_t         rdReq,
  output logic                     wrValid,
  output scl_pkg::scl_wr_t         wrData,
  output logic                     modeApply,
  output logic [3:0]               modeSwitch,
  output logic                     progStart
);

  // ----------------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_BOOT, ST_SOL, ST_SW, ST_SWCOL, ST_IDX, ST_COLON, ST_SUB, ST_OP,
    ST_BITN, ST_BITV, ST_VAL, ST_SKIP, ST_EXEC, ST_MODE, ST_RUN
  } scl_st_t;

  scl_st_t          st_ff, nxt_st;
  logic [15:0]      idx_ff, nxt_idx;
  logic [7:0]       sub_ff, nxt_sub;
  logic [31:0]      val_ff, nxt_val;
  logic [2:0]       cnt_ff, nxt_cnt;
  logic [7:0]       bitn_ff, nxt_bitn;
  logic             bitv_ff, nxt_bitv;
  logic             hex_ff, nxt_hex;
  logic             pre_ff, nxt_pre;
  logic [3:0]       valn_ff, nxt_valn;
  logic             cond_ff, nxt_cond;
  logic             first_ff, nxt_first;
  scl_pkg::scl_op_t op_ff, nxt_op;
  logic             wrV_ff, nxt_wrV;
  scl_pkg::scl_wr_t wrD_ff, nxt_wrD;
  logic             cc_ff, nxt_cc;
  logic             sw_ff, nxt_sw;
  logic             ma_ff, nxt_ma;
  logic [3:0]       ms_ff, nxt_ms;
  logic             ps_ff, nxt_ps;
  logic             end_ff, nxt_end;
  logic             rdy_ff, nxt_rdy;

  logic             isHex;
  logic             isDec;
  logic [3:0]       nib;
  logic [31:0]      decNext;
  logic             take;
  logic             eol;

  scl_char_class u_cls (
    .ch     (chData),
    .isHex  (isHex),
    .isDec  (isDec),
    .nibble (nib)
  );

  assign take    = chValid && chReady;
  assign eol     = (chData == scl_pkg::CH_LF);
  assign decNext = 32'(val_ff * 32'h0000000A) + {28'h0000000, nib};

  // ----------------------------------------------------------------------
  // Parser next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff; nxt_idx = idx_ff; nxt_sub = sub_ff; nxt_val = val_ff;
    nxt_cnt = cnt_ff; nxt_bitn = bitn_ff; nxt_bitv = bitv_ff; nxt_hex = hex_ff;
    nxt_pre = pre_ff; nxt_valn = valn_ff; nxt_cond = cond_ff;
    nxt_first = first_ff; nxt_op = op_ff;
    nxt_wrV = 1'b0; nxt_wrD = wrD_ff; nxt_cc = 1'b0; nxt_sw = 1'b0;
    nxt_ma = 1'b0; nxt_ms = ms_ff; nxt_ps = 1'b0;
    nxt_end = end_ff;
    case (st_ff)
      ST_BOOT: begin
        nxt_cc = !cfgPresent;
        nxt_sw = 1'b1;
        nxt_st = cfgPresent ? ST_SOL : ST_MODE;
      end
      ST_SOL: if (take) begin
        nxt_idx = 16'h0000; nxt_sub = scl_pkg::SUB_DEFAULT;
        nxt_val = scl_pkg::VAL_RESET; nxt_cnt = 3'd0; nxt_cond = 1'b1;
        nxt_hex = 1'b0; nxt_pre = 1'b0; nxt_valn = 4'h0; nxt_first = 1'b1;
        nxt_op = scl_pkg::OP_WRITE;
        if (chData == scl_pkg::CH_SEMI) nxt_st = ST_SKIP;
        else if (chData == scl_pkg::CH_HASH) nxt_st = ST_SW;
        else if (isHex) begin
          nxt_idx = {12'h000, nib}; nxt_cnt = 3'd1; nxt_st = ST_IDX;
        end else if (eol || chData == scl_pkg::CH_CR) nxt_st = ST_SOL;
        else nxt_st = ST_SKIP;
      end
      ST_SW: if (take) begin
        if (isDec && nib >= 4'(scl_pkg::SW_MIN) && nib <= 4'(scl_pkg::SW_MAX)) begin
          nxt_cond = dipSwitch[2'(nib - 4'h1)];
          nxt_st = ST_SWCOL;
        end else nxt_st = eol ? ST_SOL : ST_SKIP;
      end
      ST_SWCOL: if (take) nxt_st = (chData == scl_pkg::CH_COLON) ? ST_COLON :
                                   (eol ? ST_SOL : ST_SKIP);
      ST_COLON: if (take) begin
        if (isHex) begin
          nxt_idx = {12'h000, nib}; nxt_cnt = 3'd1; nxt_st = ST_IDX;
        end else nxt_st = eol ? ST_SOL : ST_SKIP;
      end
      ST_IDX: if (take) begin
        if (cnt_ff < 3'(scl_pkg::IDX_DIGITS)) begin
          if (isHex) begin
            nxt_idx = {idx_ff[11:0], nib}; nxt_cnt = 3'(cnt_ff + 3'd1);
          end else nxt_st = eol ? ST_SOL : ST_SKIP;
        end else if (chData == scl_pkg::CH_COLON) begin
          nxt_cnt = 3'd0; nxt_st = ST_SUB;
        end else begin
          nxt_cnt = 3'(scl_pkg::SUB_DIGITS);
          nxt_st = ST_OP;
          if (chData == scl_pkg::CH_EQ) begin
            nxt_op = scl_pkg::OP_WRITE; nxt_st = ST_VAL;
          end else if (chData != scl_pkg::CH_OR && chData != scl_pkg::CH_AND &&
                       chData != scl_pkg::CH_DOT) nxt_st = eol ? ST_SOL : ST_SKIP;
          else if (chData == scl_pkg::CH_DOT) begin
            nxt_cnt = 3'd0; nxt_st = ST_BITN; nxt_op = scl_pkg::OP_BIT;
          end else begin
            nxt_op = (chData == scl_pkg::CH_OR) ? scl_pkg::OP_OR : scl_pkg::OP_AND;
            nxt_pre = 1'b1;
          end
        end
      end
      ST_SUB: if (take) begin
        if (cnt_ff < 3'(scl_pkg::SUB_DIGITS) && isHex) begin
          nxt_sub = {sub_ff[3:0], nib}; nxt_cnt = 3'(cnt_ff + 3'd1);
          if (cnt_ff == 3'(scl_pkg::SUB_DIGITS - 1)) nxt_st = ST_OP;
        end else nxt_st = eol ? ST_SOL : ST_SKIP;
      end
      ST_OP: if (take) begin
        // After an operator char the = must follow directly
        if (op_ff != scl_pkg::OP_WRITE && cnt_ff == 3'(scl_pkg::SUB_DIGITS) &&
            pre_ff) begin
          nxt_st = (chData == scl_pkg::CH_EQ) ? ST_VAL : (eol ? ST_SOL : ST_SKIP);
        end else if (chData == scl_pkg::CH_EQ) begin
          nxt_op = scl_pkg::OP_WRITE; nxt_st = ST_VAL;
        end else if (chData == scl_pkg::CH_DOT) begin
          nxt_op = scl_pkg::OP_BIT; nxt_cnt = 3'd0; nxt_st = ST_BITN;
        end else if (chData == scl_pkg::CH_OR || chData == scl_pkg::CH_AND) begin
          nxt_op = (chData == scl_pkg::CH_OR) ? scl_pkg::OP_OR : scl_pkg::OP_AND;
          nxt_pre = 1'b1;
        end else nxt_st = eol ? ST_SOL : ST_SKIP;
        if (op_ff != scl_pkg::OP_WRITE && pre_ff && chData == scl_pkg::CH_EQ)
          nxt_pre = 1'b0;
      end
      ST_BITN: if (take) begin
        if (isDec && cnt_ff < 3'(scl_pkg::BIT_DIGITS)) begin
          nxt_bitn = 8'(bitn_ff * 8'h0A + {4'h0, nib});
          if (cnt_ff == 3'd0) nxt_bitn = {4'h0, nib};
          nxt_cnt = 3'(cnt_ff + 3'd1);
        end else if (cnt_ff == 3'(scl_pkg::BIT_DIGITS) && chData == scl_pkg::CH_EQ)
          nxt_st = ST_BITV;
        else nxt_st = eol ? ST_SOL : ST_SKIP;
      end
      ST_BITV: if (take) begin
        if (chData == scl_pkg::CH_ZERO || chData == scl_pkg::CH_ONE) begin
          nxt_bitv = (chData == scl_pkg::CH_ONE); nxt_valn = 4'h1;
          nxt_st = ST_VAL;
        end else nxt_st = eol ? ST_SOL : ST_SKIP;
      end
      ST_VAL: if (take) begin
        if (eol || chData == scl_pkg::CH_CR) begin
          nxt_st = (valn_ff != 4'h0 && cond_ff) ? ST_EXEC :
                   (eol ? ST_SOL : ST_SKIP);
        end else if (op_ff == scl_pkg::OP_BIT) nxt_st = ST_SKIP;
        else if (first_ff && chData == scl_pkg::CH_ZERO && !hex_ff) begin
          nxt_first = 1'b0; nxt_valn = 4'h1; nxt_val = scl_pkg::VAL_RESET;
        end else if (valn_ff == 4'h1 && val_ff == 32'h0 && !hex_ff && !first_ff &&
                     (chData == scl_pkg::CH_XLOW || chData == scl_pkg::CH_XUP)) begin
          nxt_hex = 1'b1; nxt_valn = 4'h0;
        end else if (hex_ff && isHex) begin
          nxt_val = {val_ff[27:0], nib}; nxt_valn = 4'h1;
        end else if (!hex_ff && isDec) begin
          nxt_val = decNext; nxt_valn = 4'h1; nxt_first = 1'b0;
        end else nxt_st = ST_SKIP;
      end
      ST_EXEC: begin
        // One write per executed line, in file order, unchecked
        nxt_wrV = 1'b1;
        nxt_wrD.index = idx_ff; nxt_wrD.subIndex = sub_ff;
        case (op_ff)
          scl_pkg::OP_OR:  nxt_wrD.value = rdValue | val_ff;
          scl_pkg::OP_AND: nxt_wrD.value = rdValue & val_ff;
          scl_pkg::OP_BIT: begin
            nxt_wrD.value = rdValue;
            nxt_wrD.value[bitn_ff[4:0]] = bitv_ff;
          end
          default: nxt_wrD.value = val_ff;
        endcase
        nxt_st = end_ff ? ST_MODE : ST_SOL;
      end
      ST_SKIP: if (take && eol) nxt_st = ST_SOL;
      ST_MODE: begin
        nxt_ma = 1'b1; nxt_ms = dipSwitch;
        nxt_st = ST_RUN;
      end
      ST_RUN: nxt_ps = 1'b1;
      default: nxt_st = ST_BOOT;
    endcase
    // A final character that completes a value still executes its line
    if (take && chLast && nxt_st == ST_VAL && nxt_valn != 4'h0 && cond_ff)
      nxt_st = ST_EXEC;
    if (take && chLast) nxt_end = 1'b1;
    if (take && chLast && nxt_st != ST_EXEC && st_ff != ST_EXEC) nxt_st = ST_MODE;
    nxt_rdy = (nxt_st != ST_BOOT && nxt_st != ST_EXEC &&
               nxt_st != ST_MODE && nxt_st != ST_RUN);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_BOOT; idx_ff <= 16'h0000; sub_ff <= 8'h00; val_ff <= 32'h0;
      cnt_ff <= 3'd0; bitn_ff <= 8'h00; bitv_ff <= 1'b0; hex_ff <= 1'b0;
      pre_ff <= 1'b0; valn_ff <= 4'h0; cond_ff <= 1'b1; first_ff <= 1'b1;
      op_ff <= scl_pkg::OP_WRITE; wrV_ff <= 1'b0; wrD_ff <= '0; cc_ff <= 1'b0;
      sw_ff <= 1'b0; ma_ff <= 1'b0; ms_ff <= 4'h0; ps_ff <= 1'b0;
      end_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st; idx_ff <= nxt_idx; sub_ff <= nxt_sub; val_ff <= nxt_val;
      cnt_ff <= nxt_cnt; bitn_ff <= nxt_bitn; bitv_ff <= nxt_bitv; hex_ff <= nxt_hex;
      pre_ff <= nxt_pre; valn_ff <= nxt_valn; cond_ff <= nxt_cond;
      first_ff <= nxt_first; op_ff <= nxt_op; wrV_ff <= nxt_wrV; wrD_ff <= nxt_wrD;
      cc_ff <= nxt_cc; sw_ff <= nxt_sw; ma_ff <= nxt_ma; ms_ff <= nxt_ms;
      ps_ff <= nxt_ps; end_ff <= nxt_end;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdy_ff <= 1'b0;
    else rdy_ff <= nxt_rdy;
  end

  assign chReady    = rdy_ff;
  assign cfgCreate  = cc_ff;
  assign sweepStart = sw_ff;
  assign rdReq      = '{index: idx_ff, subIndex: sub_ff};
  assign wrValid    = wrV_ff;
  assign wrData     = wrD_ff;
  assign modeApply  = ma_ff;
  assign modeSwitch = ms_ff;
  assign progStart  = ps_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_mode_before_prog: assert property (ma_ff |=> ps_ff)
    else $error("Program start did not follow mode apply");
  a_no_prog_early: assert property (ps_ff |-> $past(ps_ff) || $past(ma_ff))
    else $error("Program started before mode apply");
  a_no_write_late: assert property (ma_ff |-> ##1 !wrV_ff [*4])
    else $error("Write after file finished");
  a_comment_silent: assert property (st_ff == ST_SOL && take &&
      chData == scl_pkg::CH_SEMI |=> st_ff == ST_SKIP)
    else $error("Comment line not skipped");
  a_write_from_exec: assert property (wrV_ff |-> $past(st_ff) == ST_EXEC)
    else $error("Write without executed line");
  a_cond_gates: assert property (st_ff == ST_EXEC |-> cond_ff)
    else $error("Conditional line executed with switch off");
  a_plain_value: assert property (st_ff == ST_EXEC && op_ff == scl_pkg::OP_WRITE
      |=> wrV_ff && wrData.value == $past(val_ff))
    else $error("Plain value altered");
  a_boot_create: assert property (st_ff == ST_BOOT |=>
      cfgCreate == !$past(cfgPresent))
    else $error("Create flag wrong at boot");
  a_sweep_once: assert property (sweepStart |=> !sweepStart [*3])
    else $error("Sweep pulsed twice");

  c_write: cover property (wrV_ff);
  c_cond_skip: cover property (st_ff == ST_VAL && !cond_ff && take && eol);
  c_bit_op: cover property (wrV_ff && $past(op_ff) == scl_pkg::OP_BIT);
  c_prog: cover property (progStart);

endmodule

// file: sim/scl_host_model.sv
`timescale 1ns/10ps

// ---------------------------------------------------------------------------
// Host side: streams a stored configuration file to the interpreter
// ---------------------------------------------------------------------------
module scl_host_model (
  input  wire logic       clk,
  input  wire logic       chReady,
  output logic [7:0]      chData,
  output logic            chValid,
  output logic            chLast
);
  initial begin
    chData  = 8'h00;
    chValid = 1'b0;
    chLast  = 1'b0;
  end

  // Lines are written whole, flush left, fixed-width fields
  task automatic send(input string s, output bit ok);
    int i;
    int k;
    ok = 1'b1;
    for (i = 0; i < s.len(); i++) begin
      chData  = s[i];
      chValid = 1'b1;
      chLast  = (i == s.len() - 1);
      k = 0;
      // Ready is settled here and holds up to the next rising edge
      while (chReady !== 1'b1 && k < 200) begin
        @(negedge clk);
        k++;
      end
      if (k >= 200) begin
        ok = 1'b0;
      end
      @(posedge clk);
      @(negedge clk);
    end
    chValid = 1'b0;
    chLast  = 1'b0;
    chData  = ~chData;
  endtask
endmodule

// file: sim/startup_config_line_interpreter_tb.sv
`timescale 1ns/10ps

module startup_config_line_interpreter_tb;

  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic                    clk        = 1'b0;
  logic                    rst_n      = 1'b0;
  logic                    cfgPresent = 1'b1;
  logic [3:0]              dipSwitch  = 4'h0;
  logic [31:0]             rdValue    = 32'h0;
  logic [7:0]              chData;
  logic                    chValid;
  logic                    chLast;
  logic                    chReady;
  logic                    cfgCreate;
  logic                    sweepStart;
  scl_pkg::scl_rd_t        rdReq;
  logic                    wrValid;
  scl_pkg::scl_wr_t        wrData;
  logic                    modeApply;
  logic [3:0]              modeSwitch;
  logic                    progStart;
  int                      nFail      = 0;
  int                      nTests     = 0;
  int                      nSweep, nCreate, nMode, nOrder;
  logic [3:0]              modeSw;
  logic [55:0]             wrQ[$];
  logic [55:0]             expQ[$];
  logic [23:0]             rdQ[$];
  logic [31:0]             mem[logic [23:0]];

  always #25 clk = ~clk;

  scl_interp i_dut (
    .clk        (clk),
    .rst_n      (rst_n),
    .cfgPresent (cfgPresent),
    .chData     (chData),
    .chValid    (chValid),
    .chLast     (chLast),
    .dipSwitch  (dipSwitch),
    .rdValue    (rdValue),
    .chReady    (chReady),
    .cfgCreate  (cfgCreate),
    .sweepStart (sweepStart),
    .rdReq      (rdReq),
    .wrValid    (wrValid),
    .wrData     (wrData),
    .modeApply  (modeApply),
    .modeSwitch (modeSwitch),
    .progStart  (progStart)
  );

  scl_host_model i_host (
    .clk     (clk),
    .chReady (chReady),
    .chData  (chData),
    .chValid (chValid),
    .chLast  (chLast)
  );

  // ---------------------------------------------------------------------------
  // Object store and output monitor
  // ---------------------------------------------------------------------------
  always @(negedge clk) begin
    if (rst_n) begin
      if (wrValid === 1'b1) begin
        wrQ.push_back(wrData);
        rdQ.push_back(rdReq);
        mem[{wrData.index, wrData.subIndex}] = wrData.value;
        if (nMode != 0) nOrder++;
      end
      if (sweepStart === 1'b1) nSweep++;
      if (cfgCreate === 1'b1) nCreate++;
      if (modeApply === 1'b1) begin
        nMode++;
        modeSw = modeSwitch;
      end
      if (progStart === 1'b1 && nMode == 0) nOrder++;
    end
    rdValue <= mem.exists(rdReq) ? mem[rdReq] : 32'h0;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic reportAndStop();
    $display("Comparisons %0d, mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Restart, stream the file, wait for the program start, judge the boot
  task automatic runFile(input logic present, input logic [3:0] sw, input string txt);
    int k;
    bit ok;
    rst_n = 1'b0;
    cfgPresent = present;
    dipSwitch = sw;
    repeat (2) @(negedge clk);
    wrQ.delete();
    rdQ.delete();
    nSweep = 0; nCreate = 0; nMode = 0; nOrder = 0;
    rst_n = 1'b1;
    ok = 1'b1;
    if (present) i_host.send(txt, ok);
    k = 0;
    while (progStart !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    if (!ok || k >= 2000) begin
      check(1, 0, "run stalled");
      reportAndStop();
    end else begin
      repeat (3) @(negedge clk);
      check(nSweep, 1, "sweep pulses");
      check(nCreate, !present, "create pulses");
      check(nMode, 1, "mode apply pulses");
      check(nOrder, 0, "startup order");
      check(modeSw, sw, "sampled switches");
      check(chReady, 0, "input closed in run");
      check(wrQ.size(), expQ.size(), "write count");
      foreach (expQ[i]) begin
        if (i < wrQ.size()) check(wrQ[i], expQ[i], "write");
        if (i < rdQ.size()) check(rdQ[i], expQ[i][55:32], "object address");
      end
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic tBasic();
    expQ = '{{16'h1000, 8'h00, 32'h5}, {16'h203B, 8'h01, 32'h258},
             {16'h2057, 8'h00, 32'h1F}, {16'hFFFF, 8'hFF, 32'hFFFFFFFF}};
    runFile(1'b1, 4'h0, {"1000=5\n;203B:01=9\n203B:01=600\n",
                         "2057=0x1F\nFFFF:FF=0xFFFFFFFF\n"});
  endtask

  task automatic tBits();
    mem.delete();
    mem[24'h320200] = 32'h10;
    expQ = '{{16'h3202, 8'h00, 32'h18}, {16'h3202, 8'h00, 32'h39},
             {16'h3202, 8'h00, 32'h09}, {16'h3202, 8'h00, 32'h08}};
    runFile(1'b1, 4'h0, {"3202:00.03=1\n3202:00|=0x21\n",
                         "3202:00&=0x0F\r\n3202:00.00=0\n"});
  endtask

  task automatic tCond();
    expQ = '{{16'h2057, 8'h00, 32'h1}, {16'h2057, 8'h00, 32'h2}, {16'h2057, 8'h00, 32'h4}};
    runFile(1'b1, 4'h5, {"2057:00=1\n#1:2057:00=2\n#2:2057:00=3\n",
                         "#3:2057=4\n#4:2057=5\n#5:2057=6\n"});
  endtask

  task automatic tBad();
    expQ = '{{16'h1234, 8'hAB, 32'h7}};
    runFile(1'b1, 4'hF, "60G0=1\n6040:0=6\nXY\n1234:AB=7");
  endtask

  task automatic tNoFile();
    expQ.delete();
    runFile(1'b0, 4'hA, "");
  endtask

  initial begin
    repeat (16) @(negedge clk);
    tBasic();
    tBits();
    tCond();
    tBad();
    tNoFile();
    tBasic();
    reportAndStop();
  end
endmodule
